// [common/sxs_pkg.sv]
/*
 * constants shared by the alu slice: bus map, command fields, opcodes,
 * status bit positions and reset values.
 * assumes a 32-bit axi4-lite register bus with a 12-bit byte address.
 */
package sxs_pkg;
  // ------------------------------------------------------------
  // bus
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CMD = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ACC = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_RES = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_FILE = 12'h200;
  localparam int FILE_DEPTH = 128;
  localparam int FILE_AW = 7;
  // ------------------------------------------------------------
  // command word fields
  // ------------------------------------------------------------
  localparam int CMD_LIT_LSB = 0;
  localparam int CMD_FADR_LSB = 8;
  localparam int CMD_DEST_BIT = 15;
  localparam int CMD_OP_LSB = 16;
  localparam int CMD_OP_W = 3;
  localparam int CMD_W = 19;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [2:0] OP_SUB_ACC_FROM_FILE = 3'h1;
  localparam logic [2:0] OP_XOR_ACC_INTO_FILE = 3'h2;
  localparam logic [2:0] OP_NIBBLE_EXCHANGE_FILE = 3'h3;
  localparam logic [2:0] OP_XOR_LITERAL_ACC = 3'h4;
  localparam logic [2:0] OP_LITERAL_MINUS_ACC = 3'h5;
  localparam logic DEST_ACC = 1'b0;
  // ------------------------------------------------------------
  // status bits and reset values
  // ------------------------------------------------------------
  localparam int ST_BORROW_INV = 0;
  localparam int ST_NIBBLE_BORROW = 1;
  localparam int ST_RESULT_NULL = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_BAD_OP = 4;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [CMD_W-1:0] CMD_RST = 19'h00000;
endpackage : sxs_pkg

// [common/sxs_alu_if.sv]
/*
 * carrier between the control top and the combinational alu core.
 * assumes both ends sit in the clk_sys domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface sxs_alu_if;
  logic [2:0] op;
  logic dest;
  logic [7:0] acc;
  logic [7:0] fval;
  logic [7:0] lit;
  logic [7:0] result;
  logic borrow_inv;
  logic nibble_borrow;
  logic result_null;
  logic upd_carry;
  logic upd_null;
  logic wr_acc;
  logic wr_file;
  logic op_ok;
  modport core (
    input op, dest, acc, fval, lit,
    output result, borrow_inv, nibble_borrow, result_null,
    output upd_carry, upd_null, wr_acc, wr_file, op_ok
  );
  modport ctrl (
    output op, dest, acc, fval, lit,
    input result, borrow_inv, nibble_borrow, result_null,
    input upd_carry, upd_null, wr_acc, wr_file, op_ok
  );
endinterface : sxs_alu_if
`default_nettype wire

// [src/sxs_alu_core.sv]
/*
 * combinational alu: result, flags and write targets for one command.
 * assumes the caller commits the outputs in a single cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module sxs_alu_core (
  // operands and results
  sxs_alu_if.core alu
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // {borrow_inv, nibble_borrow, diff}: flag set when no borrow
  function automatic logic [9:0] sxs_sub(input logic [7:0] a,
                                         input logic [7:0] w);
    logic [8:0] d;
    logic [4:0] n;
    d = {1'b0, a} - {1'b0, w};
    n = {1'b0, a[3:0]} - {1'b0, w[3:0]};
    return {~d[8], ~n[4], d[7:0]};
  endfunction : sxs_sub

  function automatic logic sxs_null(input logic [7:0] r);
    return (r == 8'h00);
  endfunction : sxs_null

  // ------------------------------------------------------------
  // operation select
  // ------------------------------------------------------------
  always_comb begin
    logic [9:0] s;
    s = 10'h000;
    alu.result = 8'h00;
    alu.borrow_inv = 1'b0;
    alu.nibble_borrow = 1'b0;
    alu.upd_carry = 1'b0;
    alu.upd_null = 1'b0;
    alu.wr_acc = 1'b0;
    alu.wr_file = 1'b0;
    alu.op_ok = 1'b1;
    case (alu.op)
      sxs_pkg::OP_SUB_ACC_FROM_FILE: begin
        s = sxs_sub(alu.fval, alu.acc);
        alu.result = s[7:0];
        alu.borrow_inv = s[9];
        alu.nibble_borrow = s[8];
        alu.upd_carry = 1'b1;
        alu.upd_null = 1'b1;
        alu.wr_acc = (alu.dest == sxs_pkg::DEST_ACC);
        alu.wr_file = (alu.dest != sxs_pkg::DEST_ACC);
      end
      sxs_pkg::OP_XOR_ACC_INTO_FILE: begin
        alu.result = alu.acc ^ alu.fval;
        alu.upd_null = 1'b1;
        alu.wr_acc = (alu.dest == sxs_pkg::DEST_ACC);
        alu.wr_file = (alu.dest != sxs_pkg::DEST_ACC);
      end
      sxs_pkg::OP_NIBBLE_EXCHANGE_FILE: begin
        alu.result = {alu.fval[3:0], alu.fval[7:4]};
        alu.wr_acc = (alu.dest == sxs_pkg::DEST_ACC);
        alu.wr_file = (alu.dest != sxs_pkg::DEST_ACC);
      end
      sxs_pkg::OP_XOR_LITERAL_ACC: begin
        alu.result = alu.acc ^ alu.lit;
        alu.upd_null = 1'b1;
        alu.wr_acc = 1'b1;
      end
      sxs_pkg::OP_LITERAL_MINUS_ACC: begin
        s = sxs_sub(alu.lit, alu.acc);
        alu.result = s[7:0];
        alu.borrow_inv = s[9];
        alu.nibble_borrow = s[8];
        alu.upd_carry = 1'b1;
        alu.upd_null = 1'b1;
        alu.wr_acc = 1'b1;
      end
      default: begin
        alu.op_ok = 1'b0;
      end
    endcase
  end

  assign alu.result_null = sxs_null(alu.result);
endmodule : sxs_alu_core
`default_nettype wire

// [src/sxs_file_regs.sv]
/*
 * file register array: one write port, two asynchronous read ports.
 * assumes writes from bus and alu never fall in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module sxs_file_regs #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read ports
  input wire logic [AW-1:0] rd_a_addr,
  output logic [7:0] rd_a_data,
  input wire logic [AW-1:0] rd_b_addr,
  output logic [7:0] rd_b_data
);
  if (DEPTH != (1 << AW)) begin : g_chk
    $error("file depth must be two to the address width");
  end

  logic [7:0] mem_r [DEPTH];
  logic [7:0] mem_nxt [DEPTH];

  always_comb begin
    mem_nxt = mem_r;
    if (wr_en) begin
      mem_nxt[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= sxs_pkg::FILE_RST;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign rd_a_data = mem_r[rd_a_addr];
  assign rd_b_data = mem_r[rd_b_addr];
endmodule : sxs_file_regs
`default_nettype wire

// [src/sxs_alu_top.sv]
/*
 * alu slice top: axi4-lite slave, accumulator, flags, command launch
 * and file register array.
 * assumes one clock, clk_sys at 200 MHz, and a well-behaved master.
 */
// What this block does
// - file-minus-accumulator subtraction, file address 0..127, updates all three flags.
// - destination bit 0 writes accumulator, 1 writes back the file register.
// - borrow flags clear when accumulator (or its low nibble) exceeds file operand.
// - accumulator xor file register, routed by destination, touches only null flag.
// - nibble exchange of a file register, routed by destination, no flags change.
// - accumulator xor 8-bit literal into accumulator, updates null flag.
// - literal minus accumulator into accumulator, same three flags and borrow sense.
`timescale 1ns/1ps
`default_nettype none
module sxs_alu_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int AW = sxs_pkg::ADDR_W;
  localparam int DW = sxs_pkg::DATA_W;
  localparam int FAW = sxs_pkg::FILE_AW;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [DW-1:0] sxs_merge(input logic [DW-1:0] old,
                                              input logic [DW-1:0] nw,
                                              input logic [3:0] strb);
    logic [DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : sxs_merge

  function automatic logic sxs_in_file(input logic [AW-1:0] a);
    return (a >= sxs_pkg::OFF_FILE) &&
           (a < sxs_pkg::OFF_FILE + AW'(4 * sxs_pkg::FILE_DEPTH));
  endfunction : sxs_in_file

  function automatic logic [FAW-1:0] sxs_file_idx(input logic [AW-1:0] a);
    return a[FAW+1:2];
  endfunction : sxs_file_idx

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic {WR_IDLE, WR_RESP} sxs_wr_t;

  sxs_wr_t wst_r, wst_nxt;
  logic aw_have_r, aw_have_nxt;
  logic [AW-1:0] awaddr_r, awaddr_nxt;
  logic w_have_r, w_have_nxt;
  logic [DW-1:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic c_r, c_nxt;
  logic nb_r, nb_nxt;
  logic z_r, z_nxt;
  logic bad_r, bad_nxt;
  logic [sxs_pkg::CMD_W-1:0] cmd_r, cmd_nxt;
  logic exec_r, exec_nxt;
  logic [7:0] res_r, res_nxt;

  logic commit;
  logic fw_en;
  logic [FAW-1:0] fw_addr;
  logic [7:0] fw_data;
  logic [7:0] f_bus;
  logic [7:0] f_alu;
  logic [FAW-1:0] cmd_fadr;
  logic [DW-1:0] stat_word;

  sxs_alu_if alu ();

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  sxs_alu_core u_core (
    .alu(alu.core)
  );

  sxs_file_regs #(
    .DEPTH(sxs_pkg::FILE_DEPTH),
    .AW(FAW)
  ) u_file (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(fw_en),
    .wr_addr(fw_addr),
    .wr_data(fw_data),
    .rd_a_addr(sxs_file_idx(s_axi_araddr)),
    .rd_a_data(f_bus),
    .rd_b_addr(cmd_fadr),
    .rd_b_data(f_alu)
  );

  // ------------------------------------------------------------
  // operand routing
  // ------------------------------------------------------------
  // file address is 7 bits, so the full 0..127 range is reachable
  assign cmd_fadr = cmd_r[sxs_pkg::CMD_FADR_LSB +: FAW];
  assign alu.op = cmd_r[sxs_pkg::CMD_OP_LSB +: sxs_pkg::CMD_OP_W];
  assign alu.dest = cmd_r[sxs_pkg::CMD_DEST_BIT];
  assign alu.lit = cmd_r[sxs_pkg::CMD_LIT_LSB +: 8];
  assign alu.acc = acc_r;
  assign alu.fval = f_alu;

  assign stat_word = DW'({bad_r, exec_r, z_r, nb_r, c_r});

  // ------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------
  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready = ~w_have_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid = (wst_r == WR_RESP);
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  assign commit = aw_have_r & w_have_r & (wst_r == WR_IDLE);

  // ------------------------------------------------------------
  // write channel and register updates
  // ------------------------------------------------------------
  // the alu commits one cycle after a command write; the next bus
  // write cannot commit before that, so the file port never clashes
  always_comb begin
    logic [DW-1:0] wv, cv;
    wv = sxs_merge({DW{1'b0}}, wdata_r, wstrb_r);
    cv = sxs_merge(DW'(cmd_r), wdata_r, wstrb_r);
    wst_nxt = wst_r;
    aw_have_nxt = aw_have_r;
    awaddr_nxt = awaddr_r;
    w_have_nxt = w_have_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    acc_nxt = acc_r;
    c_nxt = c_r;
    nb_nxt = nb_r;
    z_nxt = z_r;
    bad_nxt = bad_r;
    cmd_nxt = cmd_r;
    exec_nxt = 1'b0;
    res_nxt = res_r;
    fw_en = 1'b0;
    fw_addr = cmd_fadr;
    fw_data = alu.result;
    if (s_axi_awvalid && !aw_have_r) begin
      aw_have_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (exec_r) begin
      bad_nxt = ~alu.op_ok;
      res_nxt = alu.op_ok ? alu.result : res_r;
      if (alu.wr_acc) begin
        acc_nxt = alu.result;
      end
      if (alu.wr_file) begin
        fw_en = 1'b1;
      end
      if (alu.upd_carry) begin
        c_nxt = alu.borrow_inv;
        nb_nxt = alu.nibble_borrow;
      end
      if (alu.upd_null) begin
        z_nxt = alu.result_null;
      end
    end
    if (commit) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      wst_nxt = WR_RESP;
      bresp_nxt = sxs_pkg::RESP_OKAY;
      if (awaddr_r == sxs_pkg::OFF_CMD) begin
        cmd_nxt = cv[sxs_pkg::CMD_W-1:0];
        exec_nxt = 1'b1;
      end else if (awaddr_r == sxs_pkg::OFF_ACC) begin
        if (wstrb_r[0]) begin
          acc_nxt = wv[7:0];
        end
      end else if (awaddr_r == sxs_pkg::OFF_STAT) begin
        if (wstrb_r[0]) begin
          c_nxt = wv[sxs_pkg::ST_BORROW_INV];
          nb_nxt = wv[sxs_pkg::ST_NIBBLE_BORROW];
          z_nxt = wv[sxs_pkg::ST_RESULT_NULL];
        end
      end else if (awaddr_r == sxs_pkg::OFF_RES) begin
        bresp_nxt = sxs_pkg::RESP_OKAY;
      end else if (sxs_in_file(awaddr_r)) begin
        fw_en = wstrb_r[0];
        fw_addr = sxs_file_idx(awaddr_r);
        fw_data = wv[7:0];
      end else begin
        bresp_nxt = sxs_pkg::RESP_SLVERR;
      end
    end
    if ((wst_r == WR_RESP) && s_axi_bready) begin
      wst_nxt = WR_IDLE;
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = sxs_pkg::RESP_OKAY;
      rdata_nxt = {DW{1'b0}};
      if (s_axi_araddr == sxs_pkg::OFF_CMD) begin
        rdata_nxt = DW'(cmd_r);
      end else if (s_axi_araddr == sxs_pkg::OFF_ACC) begin
        rdata_nxt = DW'(acc_r);
      end else if (s_axi_araddr == sxs_pkg::OFF_STAT) begin
        rdata_nxt = stat_word;
      end else if (s_axi_araddr == sxs_pkg::OFF_RES) begin
        rdata_nxt = DW'(res_r);
      end else if (sxs_in_file(s_axi_araddr)) begin
        rdata_nxt = DW'(f_bus);
      end else begin
        rresp_nxt = sxs_pkg::RESP_SLVERR;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wst_r <= WR_IDLE;
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
      bresp_r <= sxs_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= sxs_pkg::RESP_OKAY;
      acc_r <= sxs_pkg::ACC_RST;
      c_r <= sxs_pkg::FLAG_RST;
      nb_r <= sxs_pkg::FLAG_RST;
      z_r <= sxs_pkg::FLAG_RST;
      bad_r <= 1'b0;
      cmd_r <= sxs_pkg::CMD_RST;
      exec_r <= 1'b0;
      res_r <= 8'h00;
    end else begin
      wst_r <= wst_nxt;
      aw_have_r <= aw_have_nxt;
      awaddr_r <= awaddr_nxt;
      w_have_r <= w_have_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      acc_r <= acc_nxt;
      c_r <= c_nxt;
      nb_r <= nb_nxt;
      z_r <= z_nxt;
      bad_r <= bad_nxt;
      cmd_r <= cmd_nxt;
      exec_r <= exec_nxt;
      res_r <= res_nxt;
    end
  end
endmodule : sxs_alu_top
`default_nettype wire

// [tb/sxs_alu_properties.sv]
/*
 * bus-level properties of the alu slice, bound to its top.
 * assumes one write and one read at most under way at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module sxs_alu_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic aw_r, aw_nxt, w_r, w_nxt, hole;
  logic [11:0] ra_r, ra_nxt;
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    ra_nxt = ra_r;
    if (s_axi_bvalid && s_axi_bready) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) aw_nxt = 1'b1;
    if (s_axi_wvalid && s_axi_wready) w_nxt = 1'b1;
    if (s_axi_arvalid && s_axi_arready) ra_nxt = s_axi_araddr;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      ra_r <= 12'h000;
    end else begin
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      ra_r <= ra_nxt;
    end
  end
  // aligned words outside the map
  assign hole = (ra_r[1:0] == 2'h0) && (ra_r > 12'h00C) && !(ra_r >= 12'h200 && ra_r <= 12'h3FC);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_aw_blocked: assert property (aw_r && !s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while one held");
  a_b_caused: assert property ($rose(s_axi_bvalid) |-> aw_r && w_r)
    else $error("write response without address and data");
  a_r_released: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_hole_slverr: assert property (s_axi_rvalid && hole
      |-> s_axi_rresp == sxs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_stat_upper: assert property (s_axi_rvalid && ra_r == sxs_pkg::OFF_STAT
      |-> s_axi_rresp == sxs_pkg::RESP_OKAY && s_axi_rdata[31:5] == 27'h0)
    else $error("status read carries stray bits");
endmodule : sxs_alu_properties
bind sxs_alu_top sxs_alu_properties sxs_alu_properties_inst (.clk_sys(clk_sys), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// [tb/sxs_alu_tb_top.sv]
/*
 * self-checking bench: axi4-lite master tasks, a model of accumulator,
 * flags and file, corner cases then seeded random commands.
 * assumes the slice holds at most one write and one read.
 */
`timescale 1ns/1ps
`default_nettype none
`define SXS_CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
  end \
end
module sxs_alu_tb_top;
  logic clk_sys, rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int seed, compares, n_fail, cycles;
  logic [7:0] acc_m, res_m;
  logic [7:0] file_m [128];
  logic [2:0] flg_m;
  logic bad_m;
  sxs_alu_top sxs_alu_top_inst (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  // ready is sampled in the edge's active region, before any register moves
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    int st;
    done = 1'b0;
    st = $unsigned($random(seed)) % 3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        `SXS_CHK("bresp", er, s_axi_bresp)
      end else if (s_axi_bvalid && st == 0) s_axi_bready <= 1'b1;
      else if (s_axi_bvalid) st--;
    end
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er,
                        input string nm);
    logic done;
    int st;
    done = 1'b0;
    st = $unsigned($random(seed)) % 3;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        `SXS_CHK(nm, e, s_axi_rdata)
        `SXS_CHK(nm, er, s_axi_rresp)
      end else if (s_axi_rvalid && st == 0) s_axi_rready <= 1'b1;
      else if (s_axi_rvalid) st--;
    end
  endtask : rd_chk
  // ------------------------------------------------------------
  // model and checks
  // ------------------------------------------------------------
  function automatic logic [11:0] fadr(input logic [6:0] fa);
    return sxs_pkg::OFF_FILE + {3'h0, fa, 2'h0};
  endfunction : fadr
  function automatic void model(input logic [2:0] op, input logic d, input logic [6:0] fa,
                                input logic [7:0] k);
    logic [7:0] f, y;
    f = file_m[fa];
    y = 8'h00;
    bad_m = 1'b0;
    case (op)
      sxs_pkg::OP_SUB_ACC_FROM_FILE: y = f - acc_m;
      sxs_pkg::OP_XOR_ACC_INTO_FILE: y = f ^ acc_m;
      sxs_pkg::OP_NIBBLE_EXCHANGE_FILE: y = {f[3:0], f[7:4]};
      sxs_pkg::OP_XOR_LITERAL_ACC: y = acc_m ^ k;
      sxs_pkg::OP_LITERAL_MINUS_ACC: y = k - acc_m;
      default: bad_m = 1'b1;
    endcase
    if (op == sxs_pkg::OP_SUB_ACC_FROM_FILE) flg_m = {y == 8'h00, acc_m[3:0] <= f[3:0], acc_m <= f};
    if (op == sxs_pkg::OP_LITERAL_MINUS_ACC) flg_m = {y == 8'h00, acc_m[3:0] <= k[3:0], acc_m <= k};
    if (op == sxs_pkg::OP_XOR_ACC_INTO_FILE || op == sxs_pkg::OP_XOR_LITERAL_ACC) flg_m[2] = y == 8'h00;
    if (!bad_m) res_m = y;
    if (!bad_m && op <= 3'h3 && d) file_m[fa] = y;
    else if (!bad_m) acc_m = y;
  endfunction : model
  task automatic check_all(input logic [6:0] fa);
    rd_chk(sxs_pkg::OFF_ACC, {24'h0, acc_m}, 2'h0, "acc");
    rd_chk(sxs_pkg::OFF_STAT, {27'h0, bad_m, 1'b0, flg_m}, 2'h0, "status");
    rd_chk(fadr(fa), {24'h0, file_m[fa]}, 2'h0, "file");
    rd_chk(sxs_pkg::OFF_RES, {24'h0, res_m}, 2'h0, "result");
  endtask : check_all
  task automatic do_op(input logic pre, input logic [2:0] op, input logic d, input logic [6:0] fa,
                       input logic [7:0] k, input logic [7:0] a, input logic [7:0] f,
                       input logic [2:0] fl);
    if (pre) begin
      wr(sxs_pkg::OFF_ACC, {24'h0, a}, 2'h0);
      wr(fadr(fa), {24'h0, f}, 2'h0);
      wr(sxs_pkg::OFF_STAT, {29'h0, fl}, 2'h0);
      acc_m = a;
      file_m[fa] = f;
      flg_m = fl;
    end
    wr(sxs_pkg::OFF_CMD, {13'h0, op, d, fa, k}, 2'h0);
    model(op, d, fa, k);
    check_all(fa);
  endtask : do_op
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // ------------------------------------------------------------
  // clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // roughly 110 commands of some 16 to 44 cycles each
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_sys);
      cycles++;
      if (cycles == 30000) begin
        n_fail++;
        print_verdict();
      end
    end
  end
  initial begin
    logic [31:0] r1, r2;
    seed = 32'hE7DE;
    {compares, n_fail} = 64'h0;
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {acc_m, res_m, flg_m, bad_m} = 20'h00000;
    for (int i = 0; i < 128; i++) file_m[i] = 8'h00;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check_all(7'h7F);
    rd_chk(12'h010, 32'h0, sxs_pkg::RESP_SLVERR, "unmapped");
    rd_chk(12'hFFC, 32'h0, sxs_pkg::RESP_SLVERR, "unmapped");
    wr(12'h404, 32'h5A, sxs_pkg::RESP_SLVERR);
    do_op(1'b1, 3'h1, 1'b0, 7'h00, 8'h00, 8'h5A, 8'h5A, 3'h0);
    do_op(1'b1, 3'h1, 1'b1, 7'h7F, 8'h00, 8'h10, 8'h0F, 3'h4);
    do_op(1'b1, 3'h1, 1'b0, 7'h01, 8'h00, 8'h0F, 8'h10, 3'h0);
    do_op(1'b1, 3'h2, 1'b1, 7'h7F, 8'h00, 8'h3C, 8'h3C, 3'h3);
    do_op(1'b1, 3'h3, 1'b1, 7'h40, 8'h00, 8'h00, 8'hA5, 3'h5);
    do_op(1'b1, 3'h3, 1'b0, 7'h41, 8'h00, 8'hFF, 8'h00, 3'h2);
    do_op(1'b1, 3'h4, 1'b1, 7'h02, 8'hFF, 8'hFF, 8'h11, 3'h3);
    do_op(1'b1, 3'h5, 1'b0, 7'h03, 8'h00, 8'h01, 8'h00, 3'h4);
    do_op(1'b1, 3'h5, 1'b1, 7'h03, 8'hFF, 8'hFF, 8'h00, 3'h0);
    for (int u = 0; u < 3; u++) begin
      do_op(1'b1, (u == 0) ? 3'h0 : 3'(u + 5), 1'b0, 7'h04, 8'h77, 8'h21, 8'h12, 3'h5);
    end
    // random commands; those with r2[24] clear skip the preload and run on the accumulator and file left by the previous one
    for (int n = 0; n < 100; n++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      do_op(r2[24], 3'h1 + 3'(r1[7:0] % 5), r1[8], r1[15:9], r1[23:16], r1[31:24],
            r2[7:0], r2[10:8]);
    end
    print_verdict();
  end
endmodule : sxs_alu_tb_top
`default_nettype wire
